// *** logic/acu_top.v ***
// axis comparator unit: five comparators with apb register file
`include "acu_defs.vh"

module acu_top #(
    parameter W = 28,
    parameter NCMP = 5
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire [W-1:0] command_position_counter_i,
    input wire [W-1:0] mech_position_counter_i,
    input wire [W-1:0] deflection_counter_i,
    input wire [W-1:0] general_purpose_counter_i,
    input wire [W-1:0] positioning_counter_i,
    input wire [W-1:0] current_speed_i,
    input wire [5:0] src_count_up_i,
    input wire [W-1:0] preset_amount_prereg_i,
    output wire [W-1:0] preset_amount_active_o,
    output wire [NCMP-1:0] cmp_satisfied_o,
    output wire stop_now_o,
    output wire stop_decel_o,
    output wire rewrite_o,
    output wire index_sync_output_o,
    output wire ring_cmd_counter_o,
    output wire ring_mech_counter_o,
    output wire irq_n_o
);

// ----------------------------------------------------------------
// reset release
// ----------------------------------------------------------------
reg rst_meta_ff;
reg rst_sync_ff;

always @(posedge sys_clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        rst_meta_ff <= 1'b0;
        rst_sync_ff <= 1'b0;
    end
    else
    begin
        rst_meta_ff <= 1'b1;
        rst_sync_ff <= rst_meta_ff;
    end
end

wire rst_n = rst_sync_ff;

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [W-1:0] setting_ff [0:NCMP-1];
reg [31:0] compare_config_a_ff;
reg [31:0] compare_config_b_ff;
reg [31:0] event_irq_enable_ff;
reg [NCMP-1:0] event_irq_cause_ff;
reg [NCMP-1:0] sat_ff;
reg [31:0] prdata_ff;
reg pready_ff;
reg pslverr_ff;
reg [W-1:0] preset_active_ff;
reg stop_now_ff;
reg stop_decel_ff;
reg rewrite_ff;
reg index_ff;
reg irq_n_ff;
reg ring1_ff;
reg ring2_ff;

// ----------------------------------------------------------------
// field extraction
// ----------------------------------------------------------------
reg [2:0] src_sel [0:NCMP-1];
reg [3:0] method [0:NCMP-1];
reg [1:0] action [0:NCMP-1];

always @*
begin
    src_sel[0] = {1'b0, compare_config_a_ff[`ACU_SRC1_LSB +: 2]};
    src_sel[1] = {1'b0, compare_config_a_ff[`ACU_SRC2_LSB +: 2]};
    src_sel[2] = {1'b0, compare_config_a_ff[`ACU_SRC3_LSB +: 2]};
    src_sel[3] = {1'b0, compare_config_a_ff[`ACU_SRC4_LSB +: 2]};
    src_sel[4] = compare_config_b_ff[`ACU_SRC5_LSB +: 3];
    method[0] = {1'b0, compare_config_a_ff[`ACU_MTH1_LSB +: 3]};
    method[1] = {1'b0, compare_config_a_ff[`ACU_MTH2_LSB +: 3]};
    method[2] = {1'b0, compare_config_a_ff[`ACU_MTH3_LSB +: 3]};
    method[3] = compare_config_a_ff[`ACU_MTH4_LSB +: 4];
    method[4] = {1'b0, compare_config_b_ff[`ACU_MTH5_LSB +: 3]};
    action[0] = compare_config_a_ff[`ACU_ACT1_LSB +: 2];
    action[1] = compare_config_a_ff[`ACU_ACT2_LSB +: 2];
    action[2] = compare_config_a_ff[`ACU_ACT3_LSB +: 2];
    action[3] = compare_config_a_ff[`ACU_ACT4_LSB +: 2];
    action[4] = compare_config_b_ff[`ACU_ACT5_LSB +: 2];
end

// ----------------------------------------------------------------
// source selection
// ----------------------------------------------------------------
wire [W-1:0] defl_abs;
wire [W-1:0] defl_mag;

// deflection compared by magnitude, clipped to its range
assign defl_mag = deflection_counter_i[W-1] ?
    (~deflection_counter_i + {{(W-1){1'b0}}, 1'b1}) :
    deflection_counter_i;
assign defl_abs = (defl_mag > `ACU_DEFL_MAX) ?
    `ACU_DEFL_MAX : defl_mag;

function [W:0] f_source;
    input [2:0] sel;
    input [W-1:0] c1;
    input [W-1:0] c2;
    input [W-1:0] c3;
    input [W-1:0] c4;
    input [W-1:0] cp;
    input [W-1:0] cs;
    input [5:0] up;
    begin
        // msb carries the count direction
        case (sel)
            `ACU_S_CNT1: f_source = {up[0], c1};
            `ACU_S_CNT2: f_source = {up[1], c2};
            `ACU_S_CNT3: f_source = {up[2], c3};
            `ACU_S_CNT4: f_source = {up[3], c4};
            `ACU_S_POSN: f_source = {up[4], cp};
            `ACU_S_SPEED: f_source = {up[5], cs};
            default: f_source = {up[0], c1};
        endcase
    end
endfunction

// ----------------------------------------------------------------
// comparator bank
// ----------------------------------------------------------------
wire [NCMP-1:0] met;

genvar gi;
generate
    for (gi = 0; gi < NCMP; gi = gi + 1)
    begin : g_cmp
        wire [W:0] src;
        assign src = f_source(src_sel[gi],
            command_position_counter_i, mech_position_counter_i,
            defl_abs, general_purpose_counter_i,
            positioning_counter_i, current_speed_i, src_count_up_i);
        acu_cmp_cell #(
            .CMP_ID(gi + 1),
            .W(W)
        ) u_cell (
            .setting_i(setting_ff[gi]),
            .value_i(src[W-1:0]),
            .count_up_i(src[W]),
            .method_i(method[gi]),
            .met_o(met[gi])
        );
    end
endgenerate

// ----------------------------------------------------------------
// apb decode
// ----------------------------------------------------------------
wire acc;
wire wr_en;
wire rd_cause;
reg [31:0] rd_mux;
reg rd_hit;

assign acc = psel_i & penable_i & ~pready_ff;
assign wr_en = psel_i & penable_i & pready_ff & pwrite_i;
assign rd_cause = psel_i & penable_i & pready_ff & ~pwrite_i &
    (paddr_i == `ACU_OFS_IRQ_CAUSE);

always @*
begin
    rd_mux = `ACU_RST_WORD;
    rd_hit = 1'b1;
    case (paddr_i)
        `ACU_OFS_SET1: rd_mux = {{(32-W){1'b0}}, setting_ff[0]};
        `ACU_OFS_SET2: rd_mux = {{(32-W){1'b0}}, setting_ff[1]};
        `ACU_OFS_SET3: rd_mux = {{(32-W){1'b0}}, setting_ff[2]};
        `ACU_OFS_SET4: rd_mux = {{(32-W){1'b0}}, setting_ff[3]};
        `ACU_OFS_SET5: rd_mux = {{(32-W){1'b0}}, setting_ff[4]};
        `ACU_OFS_CFG_A: rd_mux = compare_config_a_ff;
        `ACU_OFS_CFG_B: rd_mux = compare_config_b_ff;
        `ACU_OFS_IRQ_EN: rd_mux = event_irq_enable_ff;
        `ACU_OFS_IRQ_CAUSE:
            rd_mux[`ACU_EVT_LSB +: NCMP] = event_irq_cause_ff;
        `ACU_OFS_MSTS:
            rd_mux[`ACU_EVT_LSB +: NCMP] = sat_ff;
        default: rd_hit = 1'b0;
    endcase
end

// one wait state: data and ready come straight from flops
always @(posedge sys_clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
        prdata_ff <= `ACU_RST_WORD;
    end
    else
    begin
        pready_ff <= acc;
        pslverr_ff <= acc & ~rd_hit;
        if (acc && !pwrite_i)
            prdata_ff <= rd_mux;
        else
            prdata_ff <= `ACU_RST_WORD;
    end
end

// ----------------------------------------------------------------
// configuration writes
// ----------------------------------------------------------------
integer k;

always @(posedge sys_clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        for (k = 0; k < NCMP; k = k + 1)
            setting_ff[k] <= `ACU_RST_SET;
        compare_config_a_ff <= `ACU_RST_WORD;
        compare_config_b_ff <= `ACU_RST_WORD;
        event_irq_enable_ff <= `ACU_RST_WORD;
    end
    else if (wr_en)
    begin
        case (paddr_i)
            `ACU_OFS_SET1: setting_ff[0] <= pwdata_i[W-1:0];
            `ACU_OFS_SET2: setting_ff[1] <= pwdata_i[W-1:0];
            `ACU_OFS_SET3: setting_ff[2] <= pwdata_i[W-1:0];
            `ACU_OFS_SET4: setting_ff[3] <= pwdata_i[W-1:0];
            `ACU_OFS_SET5: setting_ff[4] <= pwdata_i[W-1:0];
            `ACU_OFS_CFG_A: compare_config_a_ff <= pwdata_i;
            `ACU_OFS_CFG_B: compare_config_b_ff <= pwdata_i;
            `ACU_OFS_IRQ_EN: event_irq_enable_ff <= pwdata_i;
            default: compare_config_a_ff <= compare_config_a_ff;
        endcase
    end
end

// ----------------------------------------------------------------
// flags, events and actions
// ----------------------------------------------------------------
wire [NCMP-1:0] rise;
wire [NCMP-1:0] irq_en;
reg [NCMP-1:0] nxt_cause;
reg nxt_stop;
reg nxt_decel;
reg nxt_rewrite;
integer j;

assign irq_en = event_irq_enable_ff[`ACU_EVT_LSB +: NCMP];
assign rise = met & ~sat_ff;

always @*
begin
    nxt_stop = 1'b0;
    nxt_decel = 1'b0;
    nxt_rewrite = 1'b0;
    // a new event beats a clearing read
    nxt_cause = (rd_cause ? {NCMP{1'b0}} : event_irq_cause_ff) |
        (rise & irq_en);
    for (j = 0; j < NCMP; j = j + 1)
    begin
        if (rise[j])
        begin
            case (action[j])
                `ACU_A_STOP: nxt_stop = 1'b1;
                `ACU_A_DECEL: nxt_decel = 1'b1;
                `ACU_A_REWRITE: nxt_rewrite = 1'b1;
                default: nxt_stop = nxt_stop;
            endcase
        end
    end
end

always @(posedge sys_clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        sat_ff <= {NCMP{1'b0}};
        event_irq_cause_ff <= {NCMP{1'b0}};
        stop_now_ff <= 1'b0;
        stop_decel_ff <= 1'b0;
        rewrite_ff <= 1'b0;
        index_ff <= 1'b0;
        irq_n_ff <= 1'b1;
        preset_active_ff <= `ACU_RST_SET;
        ring1_ff <= 1'b0;
        ring2_ff <= 1'b0;
    end
    else
    begin
        sat_ff <= met;
        event_irq_cause_ff <= nxt_cause;
        stop_now_ff <= nxt_stop;
        stop_decel_ff <= nxt_decel;
        rewrite_ff <= nxt_rewrite;
        index_ff <= rise[3] & method[3][3];
        irq_n_ff <= ~(|nxt_cause);
        ring1_ff <= compare_config_a_ff[`ACU_RING1_BIT] &
            (method[0] == `ACU_M_EQ);
        ring2_ff <= compare_config_a_ff[`ACU_RING2_BIT] &
            (method[1] == `ACU_M_EQ);
        if (nxt_rewrite)
            preset_active_ff <= preset_amount_prereg_i;
    end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
assign prdata_o = prdata_ff;
assign pready_o = pready_ff;
assign pslverr_o = pslverr_ff;
assign preset_amount_active_o = preset_active_ff;
assign cmp_satisfied_o = sat_ff;
assign stop_now_o = stop_now_ff;
assign stop_decel_o = stop_decel_ff;
assign rewrite_o = rewrite_ff;
assign index_sync_output_o = index_ff;
assign ring_cmd_counter_o = ring1_ff;
assign ring_mech_counter_o = ring2_ff;
assign irq_n_o = irq_n_ff;

endmodule // acu_top

// *** logic/acu_defs.vh ***
// constants for the axis comparator unit
`ifndef ACU_DEFS_VH
`define ACU_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ACU_OFS_SET1 8'h00
`define ACU_OFS_SET2 8'h04
`define ACU_OFS_SET3 8'h08
`define ACU_OFS_SET4 8'h0c
`define ACU_OFS_SET5 8'h10
`define ACU_OFS_CFG_A 8'h14
`define ACU_OFS_CFG_B 8'h18
`define ACU_OFS_IRQ_EN 8'h1c
`define ACU_OFS_IRQ_CAUSE 8'h20
`define ACU_OFS_MSTS 8'h24

// ----------------------------------------------------------------
// field positions in compare_config_a / compare_config_b and the event registers
// ----------------------------------------------------------------
`define ACU_SRC1_LSB 0
`define ACU_MTH1_LSB 2
`define ACU_ACT1_LSB 5
`define ACU_RING1_BIT 7
`define ACU_SRC2_LSB 8
`define ACU_MTH2_LSB 10
`define ACU_ACT2_LSB 13
`define ACU_RING2_BIT 15
`define ACU_SRC3_LSB 16
`define ACU_MTH3_LSB 18
`define ACU_ACT3_LSB 21
`define ACU_SRC4_LSB 24
`define ACU_MTH4_LSB 26
`define ACU_ACT4_LSB 30
`define ACU_SRC5_LSB 0
`define ACU_MTH5_LSB 3
`define ACU_ACT5_LSB 6
`define ACU_EVT_LSB 8

// ----------------------------------------------------------------
// method codes
// ----------------------------------------------------------------
`define ACU_M_EQ 4'h1
`define ACU_M_EQ_UP 4'h2
`define ACU_M_EQ_DN 4'h3
`define ACU_M_GT 4'h4
`define ACU_M_LT 4'h5
`define ACU_M_SLIM 4'h6
`define ACU_M_IDX 4'h8
`define ACU_M_IDX_UP 4'h9
`define ACU_M_IDX_DN 4'ha

// ----------------------------------------------------------------
// action codes and source codes
// ----------------------------------------------------------------
`define ACU_A_NONE 2'h0
`define ACU_A_STOP 2'h1
`define ACU_A_DECEL 2'h2
`define ACU_A_REWRITE 2'h3
`define ACU_S_CNT1 3'h0
`define ACU_S_CNT2 3'h1
`define ACU_S_CNT3 3'h2
`define ACU_S_CNT4 3'h3
`define ACU_S_POSN 3'h4
`define ACU_S_SPEED 3'h5

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define ACU_RST_WORD 32'h0000_0000
`define ACU_RST_SET 28'h000_0000
`define ACU_DEFL_MAX 28'h000_7fff

`endif

// *** logic/acu_cmp_cell.v ***
// one comparator: condition decode for a single channel
`include "acu_defs.vh"

module acu_cmp_cell #(
    parameter CMP_ID = 1,
    parameter W = 28
) (
    input wire [W-1:0] setting_i,
    input wire [W-1:0] value_i,
    input wire count_up_i,
    input wire [3:0] method_i,
    output reg met_o
);

// ----------------------------------------------------------------
// signed compare and method decode
// ----------------------------------------------------------------
wire signed [W-1:0] s_set;
wire signed [W-1:0] s_val;
wire eq;
wire gt;
wire lt;

assign s_set = setting_i;
assign s_val = value_i;
assign eq = (s_set == s_val);
assign gt = (s_set > s_val);
assign lt = (s_set < s_val);

always @*
begin
    met_o = 1'b0;
    case (method_i)
        `ACU_M_EQ: met_o = eq;
        `ACU_M_EQ_UP: met_o = eq & count_up_i;
        `ACU_M_EQ_DN: met_o = eq & ~count_up_i;
        `ACU_M_GT: met_o = gt;
        `ACU_M_LT: met_o = lt;
        `ACU_M_SLIM:
        begin
            // positive limit on 1, negative on 2, never elsewhere
            if (CMP_ID == 1)
                met_o = lt;
            else if (CMP_ID == 2)
                met_o = gt;
            else
                met_o = 1'b0;
        end
        `ACU_M_IDX: met_o = (CMP_ID == 4) & eq;
        `ACU_M_IDX_UP: met_o = (CMP_ID == 4) & eq & count_up_i;
        `ACU_M_IDX_DN: met_o = (CMP_ID == 4) & eq & ~count_up_i;
        default: met_o = 1'b0;
    endcase
end

endmodule // acu_cmp_cell

// *** testbench/acu_checker.sv ***
// assertion checker for the axis comparator unit
module acu_checker #(
    parameter W = 28,
    parameter NCMP = 5
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire psel_i,
    input wire penable_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire [W-1:0] preset_amount_prereg_i,
    input wire [W-1:0] preset_amount_active_o,
    input wire [NCMP-1:0] cmp_satisfied_o,
    input wire stop_now_o,
    input wire stop_decel_o,
    input wire rewrite_o,
    input wire index_sync_output_o,
    input wire irq_n_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_first_access;
        psel_i && penable_i && !pready_o && !$past(penable_i);
    endsequence
    sequence s_new_flag;
        (cmp_satisfied_o & ~$past(cmp_satisfied_o)) != '0;
    endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    AST_PREADY_WAIT: assert property (s_first_access |=> pready_o)
        else $error("pready not one cycle after access");
    AST_PREADY_ONE: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    AST_SLVERR: assert property (pslverr_o |-> pready_o)
        else $error("slverr without pready");
    AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer");
    AST_IRQ_FELL: assert property ($fell(irq_n_o) |-> s_new_flag)
        else $error("interrupt without new flag");
    AST_IRQ_STAY: assert property (
        !irq_n_o && !pready_o |=> !irq_n_o)
        else $error("interrupt released without read");
    AST_STOP: assert property (stop_now_o |-> s_new_flag)
        else $error("stop pulse without new flag");
    AST_DECEL: assert property (stop_decel_o |-> s_new_flag)
        else $error("decel pulse without new flag");
    AST_REWRITE: assert property (rewrite_o |->
        s_new_flag ##0
        preset_amount_active_o == $past(preset_amount_prereg_i))
        else $error("rewrite without preset copy");
    AST_IDX: assert property (index_sync_output_o |->
        $rose(cmp_satisfied_o[3]))
        else $error("index pulse without cmp4 rise");
endmodule // acu_checker

bind acu_top acu_checker #(.W(W), .NCMP(NCMP)) u_acu_checker (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .preset_amount_prereg_i(preset_amount_prereg_i),
    .preset_amount_active_o(preset_amount_active_o),
    .cmp_satisfied_o(cmp_satisfied_o),
    .stop_now_o(stop_now_o),
    .stop_decel_o(stop_decel_o),
    .rewrite_o(rewrite_o),
    .index_sync_output_o(index_sync_output_o),
    .irq_n_o(irq_n_o)
);

// *** testbench/tb.sv ***
// self-checking testbench for the axis comparator unit
`include "acu_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int k; logic [3:0] m; logic [2:0] s;
        logic [27:0] v; logic [27:0] c; logic u; logic e;} acu_row_t;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, d;
    logic er;
    logic [27:0] cnt = 28'h0, pre = 28'h00abcde;
    logic [5:0] up = 6'h00;
    logic [2:0] sel = 3'h0;
    // unselected sources show the inverse, so a wrong pick shows up
    wire [27:0] src0 = (sel == 3'h0) ? cnt : ~cnt;
    wire [27:0] src1 = (sel == 3'h1) ? cnt : ~cnt;
    wire [27:0] src2 = (sel == 3'h2) ? cnt : ~cnt;
    wire [27:0] src3 = (sel == 3'h3) ? cnt : ~cnt;
    wire [27:0] src4 = (sel == 3'h4) ? cnt : ~cnt;
    wire [27:0] src5 = (sel == 3'h5) ? cnt : ~cnt;
    wire [31:0] prdata_o;
    wire [27:0] act;
    wire [4:0] sat;
    wire pready_o, pslverr_o, stp, dec, rwr, idx, rc, rm, irq_n;
    int err_total = 0;
    int comparisons = 0;
    acu_row_t rows [19] = '{
        '{1, 4'h1, 3'h0, 28'h64, 28'h64, 1'h0, 1'h1},
        '{1, 4'h1, 3'h0, 28'h64, 28'h64, 1'h1, 1'h1},
        '{2, 4'h2, 3'h1, 28'h32, 28'h32, 1'h0, 1'h0},
        '{2, 4'h2, 3'h1, 28'h32, 28'h32, 1'h1, 1'h1},
        '{3, 4'h3, 3'h1, 28'h3c, 28'h3c, 1'h1, 1'h0},
        '{3, 4'h3, 3'h1, 28'h3c, 28'h3c, 1'h0, 1'h1},
        '{5, 4'h4, 3'h4, 28'ha, 28'h9, 1'h1, 1'h1},
        '{5, 4'h4, 3'h4, 28'ha, 28'ha, 1'h1, 1'h0},
        '{5, 4'h5, 3'h5, 28'ha, 28'hb, 1'h1, 1'h1},
        '{5, 4'h5, 3'h5, 28'ha, 28'ha, 1'h1, 1'h0},
        '{1, 4'h6, 3'h0, 28'h14, 28'h15, 1'h1, 1'h1},
        '{2, 4'h6, 3'h0, 28'h14, 28'h13, 1'h1, 1'h1},
        '{3, 4'h6, 3'h0, 28'h14, 28'h15, 1'h1, 1'h0},
        '{3, 4'h6, 3'h0, 28'h14, 28'h13, 1'h1, 1'h0},
        '{4, 4'h8, 3'h3, 28'h7, 28'h7, 1'h0, 1'h1},
        '{4, 4'h9, 3'h3, 28'h7, 28'h7, 1'h0, 1'h0},
        '{4, 4'ha, 3'h3, 28'h7, 28'h7, 1'h0, 1'h1},
        '{1, 4'h1, 3'h2, 28'h5, 28'hffffffb, 1'h1, 1'h1},
        '{4, 4'h4, 3'h3, 28'h8, 28'h3, 1'h1, 1'h1}};

    acu_top u_acu_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .command_position_counter_i(src0), .mech_position_counter_i(src1),
        .deflection_counter_i(src2), .general_purpose_counter_i(src3),
        .positioning_counter_i(src4), .current_speed_i(src5),
        .src_count_up_i(up), .preset_amount_prereg_i(pre),
        .preset_amount_active_o(act), .cmp_satisfied_o(sat),
        .stop_now_o(stp), .stop_decel_o(dec), .rewrite_o(rwr),
        .index_sync_output_o(idx), .ring_cmd_counter_o(rc),
        .ring_mech_counter_o(rm), .irq_n_o(irq_n));

    always #50 sys_clk_i = ~sys_clk_i;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        d = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("rdata", e, d);
    endtask
    task drv(input logic [27:0] v, input logic u);
        @(posedge sys_clk_i);
        cnt <= v;
        up <= {6{u}};
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task summarize;
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // config_a in upper half, config_b in lower half
    function automatic logic [63:0] cfg(input acu_row_t r,
        input logic [1:0] a);
        logic [63:0] x;
        x = 64'h0;
        if (r.k == 5)
            x[7:0] = {a, r.m[2:0], r.s};
        else if (r.k == 4)
            x[63:56] = {a, r.m, r.s[1:0]};
        else
            x[32 + (r.k - 1) * 8 +: 8] = {1'b0, a, r.m[2:0], r.s[1:0]};
        return x;
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        chk("irq_n", 32'h1, irq_n);
        rd(`ACU_OFS_CFG_A, 32'h0);
        rd(`ACU_OFS_IRQ_EN, 32'h0);
        rd(`ACU_OFS_IRQ_CAUSE, 32'h0);
        foreach (rows[i])
        begin
            apb(1'b1, 8'((rows[i].k - 1) * 4), {4'h0, rows[i].v});
            apb(1'b1, `ACU_OFS_CFG_A, 32'(cfg(rows[i], 2'h0) >> 32));
            apb(1'b1, `ACU_OFS_CFG_B, 32'(cfg(rows[i], 2'h0)));
            sel <= rows[i].s;
            drv(rows[i].c, rows[i].u);
            chk("sat", 32'(rows[i].e), 32'(sat[rows[i].k - 1]));
            rd(`ACU_OFS_MSTS, 32'(rows[i].e) << (7 + rows[i].k));
        end
        // index pulse: forward-only code, setting 4 holds 8
        sel <= 3'h3;
        apb(1'b1, `ACU_OFS_CFG_A, 32'(cfg(rows[15], 2'h0) >> 32));
        drv(28'h7, 1'b1);
        drv(28'h8, 1'b1);
        chk("idx", 32'h1, idx);
        drv(28'h7, 1'b0);
        drv(28'h8, 1'b0);
        chk("idx", 32'h0, idx);
        sel <= 3'h0;
        apb(1'b1, `ACU_OFS_IRQ_EN, 32'h100);
        apb(1'b1, `ACU_OFS_SET1, 32'hc8);
        for (int a = 1; a < 4; a++)
        begin
            apb(1'b1, `ACU_OFS_CFG_A, 32'(cfg(rows[0], 2'(a)) >> 32));
            drv(28'hc7, 1'b1);
            drv(28'hc8, 1'b1);
            chk("act", {a == 1, a == 2, a == 3}, {stp, dec, rwr});
            chk("irq_n", 32'h0, irq_n);
            chk("preset", a == 3 ? pre : 28'h0, act);
            rd(`ACU_OFS_IRQ_CAUSE, 32'h100);
            rd(`ACU_OFS_IRQ_CAUSE, 32'h0);
            chk("irq_n", 32'h1, irq_n);
        end
        apb(1'b1, `ACU_OFS_IRQ_EN, 32'h0);
        drv(28'hc7, 1'b1);
        drv(28'hc8, 1'b1);
        chk("irq_n", 32'h1, irq_n);
        rd(`ACU_OFS_IRQ_CAUSE, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, er);
        chk("rdata", 32'h0, d);
        apb(1'b1, `ACU_OFS_CFG_A, 32'h8484);
        drv(28'h0, 1'b1);
        chk("ring", 32'h3, {rc, rm});
        rd(`ACU_OFS_CFG_A, 32'h8484);
        @(posedge sys_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        chk("ring", 32'h0, {rc, rm});
        rd(`ACU_OFS_CFG_A, 32'h0);
        summarize();
    end

    initial
    begin
        #2000000;
        err_total++;
        summarize();
    end
endmodule // tb
